// ==== bench/chip_core_model.sv ====
`timescale 1ns/1ps
module chip_core_model (
	// Clock, reset and bench requests
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic enableStrap,
	input  wire logic sleepReq,
	// Chip state towards the regulator
	output logic      stopMode,
	output logic      regulator_enable_in
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regulator_enable_in <= enableStrap;
			stopMode <= 1'b0;
		end else begin
			stopMode <= sleepReq;
		end
	end
endmodule : chip_core_model

// ==== bench/regulator_mode_and_low_voltage_monitor_properties.sv ====
`timescale 1ns/1ps
module regulator_mode_and_low_voltage_monitor_properties
	import regulator_pkg::*;
(
	// Clock, reset and bus
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	// Monitors and outputs
	input wire logic        coreBelowPorCmp,
	input wire logic        coreBelowLvrCmp,
	input wire logic        regulator_enable_in,
	input wire logic        stopMode,
	input wire logic        powerOnReset,
	input wire logic        low_voltage_reset,
	input wire logic        low_voltage_interrupt,
	input wire logic [1:0]  regulatorMode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic rdCtrl;
	assign rdCtrl = psel && penable && !pwrite && paddr == CTRL_OFFSET;
	a_reserved_zero: assert property (rdCtrl |-> prdata[31:3] == 29'h0)
		else $error("reserved control bits not zero");
	a_lvi_from_reg: assert property (rdCtrl && $stable(low_voltage_interrupt)
		|-> low_voltage_interrupt == (prdata[1] && prdata[0])) else $error("interrupt mismatch");
	a_status_off: assert property (rdCtrl && $past(regulatorMode, 2) != MODE_FULL
		&& $past(regulatorMode, 3) != MODE_FULL |-> !prdata[2]) else $error("status outside full");
	a_shutdown_mode: assert property (!regulator_enable_in [*5]
		|-> regulatorMode == MODE_SHUTDOWN) else $error("shutdown mode missing");
	a_reduced_mode: assert property ((regulator_enable_in && stopMode) [*5]
		|-> regulatorMode == MODE_REDUCED) else $error("reduced mode missing");
	a_full_mode: assert property ((regulator_enable_in && !stopMode) [*5]
		|-> regulatorMode == MODE_FULL) else $error("full mode missing");
	a_por_high: assert property (coreBelowPorCmp [*4] |-> powerOnReset)
		else $error("power-on reset low");
	a_por_low: assert property (!coreBelowPorCmp [*4] |-> !powerOnReset)
		else $error("power-on reset high");
	a_lvr_on: assert property ((coreBelowLvrCmp && regulatorMode == MODE_FULL) [*4]
		|-> low_voltage_reset) else $error("low-voltage reset missing");
	a_lvr_off: assert property ((regulatorMode != MODE_FULL) [*3] |-> !low_voltage_reset)
		else $error("low-voltage reset outside full");
endmodule : regulator_mode_and_low_voltage_monitor_properties

bind regulator_mode_and_low_voltage_monitor regulator_mode_and_low_voltage_monitor_properties
	chk_u (.*);

// ==== bench/regulator_mode_and_low_voltage_monitor_tb.sv ====
`timescale 1ns/1ps
module regulator_mode_and_low_voltage_monitor_tb
	import regulator_pkg::*;
;
	logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic        supplyLowCmp = 0, coreBelowPorCmp = 0, coreBelowLvrCmp = 0;
	logic        sleepReq = 0, strap = 0, pready, pslverr, powerOnReset;
	logic        low_voltage_reset, low_voltage_interrupt, irqOut, stopMode, regulator_enable_in;
	logic [11:0] paddr = 0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [1:0]  regulatorMode;
	int          n_errors = 0, compares = 0;
	always #50 clk = ~clk;
	regulator_mode_and_low_voltage_monitor dut_u (.*);
	chip_core_model model_u (.clk, .rst_b, .enableStrap(strap), .sleepReq, .stopMode,
		.regulator_enable_in);
	task chk(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xfer
	task rdc(input logic [31:0] exp);
		xfer(1'b0, CTRL_OFFSET, 32'h0);
		chk("control", exp, rd);
	endtask : rdc
	task rst(input logic v);
		rst_b <= 1'b0;
		strap <= v;
		wt(12);
		rst_b <= 1'b1;
	endtask : rst
	task t_shutdown;
		supplyLowCmp <= 1'b1;
		coreBelowLvrCmp <= 1'b1;
		wt(5);
		chk("mode", 32'(MODE_SHUTDOWN), 32'(regulatorMode));
		chk("lvr", 32'h0, 32'(low_voltage_reset));
		rdc(32'h0);
		supplyLowCmp <= 1'b0;
		coreBelowLvrCmp <= 1'b0;
	endtask : t_shutdown
	task t_regs;
		rdc(32'h0);
		xfer(1'b1, CTRL_OFFSET, 32'hFF);
		rdc(32'h2);
		pstrb <= 4'hE;
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		pstrb <= 4'hF;
		rdc(32'h2);
		xfer(1'b0, 12'h00C, 32'h0);
		chk("slverr", 32'h1, 32'(err));
	endtask : t_regs
	task t_lvd;
		supplyLowCmp <= 1'b1;
		wt(4);
		rdc(32'h7);
		chk("lvi", 32'h1, 32'(low_voltage_interrupt));
		xfer(1'b1, MASK_OFFSET, 32'h1);
		chk("irq", 32'h1, 32'(irqOut));
		xfer(1'b1, MASK_OFFSET, 32'h0);
		chk("irq", 32'h0, 32'(irqOut));
		xfer(1'b1, IRQ_OFFSET, 32'h3);
		xfer(1'b1, MASK_OFFSET, 32'h1);
		chk("irq", 32'h0, 32'(irqOut));
		xfer(1'b1, CTRL_OFFSET, 32'h2);
		rdc(32'h7);
		xfer(1'b1, CTRL_OFFSET, 32'h3);
		rdc(32'h6);
		chk("lvi", 32'h0, 32'(low_voltage_interrupt));
		supplyLowCmp <= 1'b0;
		wt(4);
		rdc(32'h3);
	endtask : t_lvd
	task t_stop;
		sleepReq <= 1'b1;
		wt(5);
		chk("mode", 32'(MODE_REDUCED), 32'(regulatorMode));
		rdc(32'h3);
		xfer(1'b1, CTRL_OFFSET, 32'h3);
		supplyLowCmp <= 1'b1;
		coreBelowLvrCmp <= 1'b1;
		wt(4);
		rdc(32'h2);
		chk("lvr", 32'h0, 32'(low_voltage_reset));
		sleepReq <= 1'b0;
		wt(6);
		rdc(32'h7);
		chk("lvr", 32'h1, 32'(low_voltage_reset));
		coreBelowPorCmp <= 1'b1;
		wt(4);
		chk("por", 32'h1, 32'(powerOnReset));
		coreBelowPorCmp <= 1'b0;
		wt(4);
		chk("por", 32'h0, 32'(powerOnReset));
	endtask : t_stop
	task results;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		results();
	end
	initial begin
		rst(1'b0);
		t_shutdown();
		rst(1'b1);
		t_regs();
		t_lvd();
		t_stop();
		results();
	end
endmodule : regulator_mode_and_low_voltage_monitor_tb

// ==== verilog/level_sync.sv ====
`timescale 1ns/1ps
module level_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Level crossing
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1;
	logic next_stage1;
	logic next_syncOut;

	always_comb begin
		next_stage1  = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1  <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			stage1  <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule : level_sync

// ==== verilog/regulator_mode_and_low_voltage_monitor.sv ====
`timescale 1ns/1ps
module regulator_mode_and_low_voltage_monitor
	import regulator_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Analog comparators and chip state
	input  wire logic        supplyLowCmp,
	input  wire logic        coreBelowPorCmp,
	input  wire logic        coreBelowLvrCmp,
	input  wire logic        regulator_enable_in,
	input  wire logic        stopMode,
	// Outputs to reset generator, interrupt controller and regulator mode
	output logic             powerOnReset,
	output logic             low_voltage_reset,
	output logic             low_voltage_interrupt,
	output logic             irqOut,
	output logic [1:0]       regulatorMode
);
	logic supplyLowSync;
	logic porSync;
	logic lvrSync;
	logic enableSync;
	logic stopSync;

	level_sync syncSupply (.clk(clk), .rst_b(rst_b), .asyncIn(supplyLowCmp),
		.syncOut(supplyLowSync));
	level_sync syncPor (.clk(clk), .rst_b(rst_b), .asyncIn(coreBelowPorCmp),
		.syncOut(porSync));
	level_sync syncLvr (.clk(clk), .rst_b(rst_b), .asyncIn(coreBelowLvrCmp),
		.syncOut(lvrSync));
	level_sync syncEnable (.clk(clk), .rst_b(rst_b), .asyncIn(regulator_enable_in),
		.syncOut(enableSync));
	level_sync syncStop (.clk(clk), .rst_b(rst_b), .asyncIn(stopMode),
		.syncOut(stopSync));

	regulator_mode_e mode;
	regulator_mode_e next_mode;
	logic            lowVoltageStatus;
	logic            next_lowVoltageStatus;
	logic            low_voltage_irq_enable;
	logic            next_low_voltage_irq_enable;
	logic            low_voltage_irq_flag;
	logic            next_low_voltage_irq_flag;
	logic [1:0]      irqStatus;
	logic [1:0]      next_irqStatus;
	logic [1:0]      irqMask;
	logic [1:0]      next_irqMask;
	logic            next_powerOnReset;
	logic            next_low_voltage_reset;
	logic [31:0]     next_prdata;
	logic            access;
	logic            writeAccess;
	logic            hitCtrl;
	logic            hitIrq;
	logic            hitMask;
	logic            statusChange;
	logic            modeChange;

	always_comb begin
		access      = psel && penable;
		writeAccess = access && pwrite && pstrb[0];
		hitCtrl     = (paddr == CTRL_OFFSET);
		hitIrq      = (paddr == IRQ_OFFSET);
		hitMask     = (paddr == MASK_OFFSET);
	end

	// Mode selection from enable and stop inputs.
	always_comb begin
		if (!enableSync) begin
			next_mode = MODE_SHUTDOWN; // R10 R11
		end else if (stopSync) begin
			next_mode = MODE_REDUCED; // R12
		end else begin
			next_mode = MODE_FULL; // R12
		end
	end

	// Low-voltage status, flag and enable.
	always_comb begin
		if (mode == MODE_FULL) begin
			next_lowVoltageStatus = supplyLowSync; // R1 R2 R7
		end else begin
			next_lowVoltageStatus = 1'b0; // R2
		end
		statusChange = (mode == MODE_FULL) && (next_lowVoltageStatus != lowVoltageStatus); // R4 R7
		next_low_voltage_irq_flag = low_voltage_irq_flag; // R6
		if (writeAccess && hitCtrl && pwdata[FLAG_BIT]) begin
			next_low_voltage_irq_flag = 1'b0; // R5
		end
		if (statusChange) begin
			next_low_voltage_irq_flag = 1'b1; // R4
		end
		next_low_voltage_irq_enable = low_voltage_irq_enable;
		if (writeAccess && hitCtrl) begin
			next_low_voltage_irq_enable = pwdata[ENABLE_BIT]; // R3
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode                   <= MODE_SHUTDOWN;
			lowVoltageStatus       <= 1'b0;
			low_voltage_irq_flag   <= 1'b0; // R13
			low_voltage_irq_enable <= 1'b0; // R13
		end else begin
			mode                   <= next_mode;
			lowVoltageStatus       <= next_lowVoltageStatus;
			low_voltage_irq_flag   <= next_low_voltage_irq_flag;
			low_voltage_irq_enable <= next_low_voltage_irq_enable;
		end
	end

	// Reset outputs.
	always_comb begin
		next_powerOnReset      = porSync; // R8
		next_low_voltage_reset = (mode == MODE_FULL) && lvrSync; // R9
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			powerOnReset      <= 1'b1;
			low_voltage_reset <= 1'b0;
		end else begin
			powerOnReset      <= next_powerOnReset;
			low_voltage_reset <= next_low_voltage_reset;
		end
	end

	// Sticky event register with write-one-to-clear and a mask.
	always_comb begin
		modeChange     = (next_mode != mode);
		next_irqStatus = irqStatus;
		if (writeAccess && hitIrq) begin
			next_irqStatus = irqStatus & ~pwdata[IRQ_WIDTH-1:0];
		end
		if (statusChange) begin
			next_irqStatus[IRQ_LV_BIT] = 1'b1;
		end
		if (modeChange) begin
			next_irqStatus[IRQ_MODE_BIT] = 1'b1;
		end
		next_irqMask = irqMask;
		if (writeAccess && hitMask) begin
			next_irqMask = pwdata[IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irqStatus <= IRQ_RESET;
			irqMask   <= IRQ_RESET;
		end else begin
			irqStatus <= next_irqStatus;
			irqMask   <= next_irqMask;
		end
	end

	// Read data.
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			if (hitCtrl) begin
				next_prdata[STATUS_BIT] = lowVoltageStatus; // R1 R13
				next_prdata[ENABLE_BIT] = low_voltage_irq_enable;
				next_prdata[FLAG_BIT]   = low_voltage_irq_flag;
			end else if (hitIrq) begin
				next_prdata[IRQ_WIDTH-1:0] = irqStatus;
			end else if (hitMask) begin
				next_prdata[IRQ_WIDTH-1:0] = irqMask;
			end
		end else if (access) begin
			next_prdata = prdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	always_comb begin
		pready                = 1'b1;
		pslverr               = access && !(hitCtrl || hitIrq || hitMask);
		low_voltage_interrupt = low_voltage_irq_enable && low_voltage_irq_flag; // R3
		irqOut                = |(irqStatus & irqMask);
		regulatorMode         = mode;
	end
endmodule : regulator_mode_and_low_voltage_monitor

// ==== verilog/regulator_pkg.sv ====
// Notes on behaviour
// R1: Status bit 2 is read-only, follows the monitor comparator, writes ignored.
// R2: Status reads 1 only when supply is low in full performance mode.
// R3: Interrupt requested while flag set and enable bit 1 is one.
// R4: Flag bit 0 sets on every status change, rising or falling; the status drop on leaving full performance mode sets no flag.
// R5: Flag clears only by writing one; writing zero leaves it unchanged.
// R6: Entering reduced power mode keeps the flag unchanged.
// R7: Detector updates status only in full performance mode.
// R8: Power-on reset output high while core supply below threshold, all modes.
// R9: Low-voltage reset follows core comparator, enabled only in full performance.
// R10: Regulator-enable low means shutdown; high means full or reduced power mode.
// R11: System must not toggle regulator-enable while the chip is powered.
// R12: Reduced power mode during stop mode, full performance otherwise, when enabled.
// R13: Enable and flag reset to zero; unused upper control bits read zero.
package regulator_pkg;

	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] IRQ_OFFSET    = 12'h004;
	localparam logic [11:0] MASK_OFFSET   = 12'h008;
	localparam int          CTRL_WIDTH    = 8;
	localparam int          STATUS_BIT    = 2;
	localparam int          ENABLE_BIT    = 1;
	localparam int          FLAG_BIT      = 0;
	localparam int          IRQ_WIDTH     = 2;
	localparam int          IRQ_LV_BIT    = 0;
	localparam int          IRQ_MODE_BIT  = 1;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [1:0]  IRQ_RESET     = 2'h0;

	typedef enum logic [1:0] {
		MODE_SHUTDOWN = 2'b00,
		MODE_FULL     = 2'b01,
		MODE_REDUCED  = 2'b10
	} regulator_mode_e;

endpackage : regulator_pkg
